// File: src/psm_pin3_mux.sv
// Purpose: pin 3 output multiplexer with driver control behind a Wishbone slave
// Assumes: one clock sys_clk at 25 MHz, synchronous active-low reset_n
// Notes:   pin level and enable are registered, so the pin follows a change one cycle later
//
// The Wishbone register port was chosen for this implementation.

`timescale 1ns/1ps

// ============================================================
// top module
// ============================================================
module psm_pin3_mux
    import psm_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [PSM_ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [PSM_DAT_W-1:0] wb_dat_i,
    output logic      [PSM_DAT_W-1:0] wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic [15:0]          rx_remote_gpio,
    input  wire logic [3:0]           rx_lock,
    input  wire logic [3:0]           rx_pass,
    input  wire logic [3:0]           rx_frame_valid,
    input  wire logic [3:0]           rx_line_valid,
    input  wire logic                 frame_sync_pulse,
    input  wire logic [1:0]           tx_frame_valid,
    input  wire logic [1:0]           tx_line_valid,
    input  wire logic [1:0]           tx_synced,
    input  wire logic [1:0]           tx_irq,
    input  wire logic                 pin3_in,
    output logic                      pin3_out,
    output logic                      pin3_oe_n
);

    // ============================================================
    // declarations
    // ============================================================
    logic [7:0]           ctrl_r;
    logic [11:0]          cfg_r;
    logic                 ack_r;
    logic [PSM_DAT_W-1:0] dat_r;
    logic                 pin_out_r;
    logic                 pin_oe_n_r;
    logic                 sel_val;
    logic                 req;
    logic                 wr_commit;
    logic [2:0]           pin3_source_group;
    logic [2:0]           pin3_signal_select;
    logic                 pin3_software_level;
    logic                 pin3_driver_enable;
    logic [3:0]           rx_en;
    logic [3:0]           tx0_map;
    logic [3:0]           tx1_map;
    logic [PSM_DAT_W-1:0] rd_val;

    // true when the byte address equals the given register byte address
    function automatic logic adr_hit(input logic [PSM_ADR_W-1:0] adr, input logic [7:0] badr);
        return adr == badr;
    endfunction : adr_hit

    // ============================================================
    // field views
    // ============================================================
    assign pin3_signal_select  = ctrl_r[PSM_SEL_MSB:PSM_SEL_LSB];
    assign pin3_source_group   = ctrl_r[PSM_SRC_MSB:PSM_SRC_LSB];
    assign pin3_software_level = ctrl_r[PSM_VAL_BIT];
    assign pin3_driver_enable  = ctrl_r[PSM_EN_BIT];
    assign rx_en               = cfg_r[3:0];
    assign tx0_map             = cfg_r[7:4];
    assign tx1_map             = cfg_r[11:8];

    // ============================================================
    // wishbone slave
    // ============================================================
    // a request is live while cycle and strobe stand; commit on the ack edge
    assign req       = wb_cyc_i & wb_stb_i;
    assign wr_commit = req & wb_we_i & ack_r;

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        rd_val = '0;
        if (adr_hit(wb_adr_i, PSM_CTRL_ADR)) begin
            rd_val[7:0] = ctrl_r;
        end else if (adr_hit(wb_adr_i, PSM_CFG_ADR)) begin
            rd_val[11:0] = cfg_r;
        end else if (adr_hit(wb_adr_i, PSM_STAT_ADR)) begin
            rd_val[3:0] = {pin3_in, ~pin_oe_n_r, pin_out_r, sel_val};
        end
    end

    // read data captured at the edge that raises ack
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            dat_r <= '0;
        end else if (req & ~ack_r) begin
            dat_r <= rd_val;
        end
    end

    // ============================================================
    // registers
    // ============================================================
    // pin control, byte lane 0
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ctrl_r <= PSM_CTRL_RST;
        end else if (wr_commit && wb_sel_i[0] && adr_hit(wb_adr_i, PSM_CTRL_ADR)) begin
            ctrl_r <= wb_dat_i[7:0];
        end
    end

    // port enable and transmit assignment, byte lanes 0 and 1
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cfg_r <= PSM_CFG_RST;
        end else if (wr_commit && adr_hit(wb_adr_i, PSM_CFG_ADR)) begin
            if (wb_sel_i[0]) begin
                cfg_r[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                cfg_r[11:8] <= wb_dat_i[11:8];
            end
        end
    end

    // ============================================================
    // source selection and pin driver
    // ============================================================
    psm_source_select u_select (
        .src              (pin3_source_group),
        .sel              (pin3_signal_select),
        .level            (pin3_software_level),
        .rx_en            (rx_en),
        .tx0_map          (tx0_map),
        .tx1_map          (tx1_map),
        .rx_remote_gpio   (rx_remote_gpio),
        .rx_lock          (rx_lock),
        .rx_pass          (rx_pass),
        .rx_frame_valid   (rx_frame_valid),
        .rx_line_valid    (rx_line_valid),
        .frame_sync_pulse (frame_sync_pulse),
        .tx_frame_valid   (tx_frame_valid),
        .tx_line_valid    (tx_line_valid),
        .tx_synced        (tx_synced),
        .tx_irq           (tx_irq),
        .sel_val          (sel_val)
    );

    // registered pin level and active-low enable
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pin_out_r  <= 1'b0;
            pin_oe_n_r <= 1'b1;
        end else begin
            pin_out_r  <= sel_val;
            pin_oe_n_r <= ~pin3_driver_enable;
        end
    end

    assign pin3_out  = pin_out_r;
    assign pin3_oe_n = pin_oe_n_r;
    assign wb_ack_o  = ack_r;
    assign wb_dat_o  = dat_r;

    // ============================================================
    // checks
    // ============================================================
    // reference values built straight from the inputs
    logic       h_rx_remote;
    logic       h_rx_lock;
    logic       h_rx_pass;
    logic       h_rx_fv;
    logic       h_or_lock;
    logic       h_and_lock;
    logic       h_and_pass;
    logic [3:0] h_tx_mask;
    logic       h_tx_and;
    logic       h_tx_fv;
    logic       h_tx_irq;
    logic       h_rx_src;
    logic       h_tx_src;

    assign h_rx_src    = pin3_source_group <= PSM_SRC_RX3;
    assign h_tx_src    = pin3_source_group >= PSM_SRC_TX0;
    assign h_rx_remote = rx_remote_gpio[{pin3_source_group[1:0], pin3_signal_select[1:0]}];
    assign h_rx_lock   = rx_lock[pin3_source_group[1:0]];
    assign h_rx_pass   = rx_pass[pin3_source_group[1:0]];
    assign h_rx_fv     = rx_frame_valid[pin3_source_group[1:0]];
    assign h_or_lock   = |(rx_lock & rx_en);
    assign h_and_lock  = (rx_en != 4'h0) && ((rx_lock & rx_en) == rx_en);
    assign h_and_pass  = (rx_en != 4'h0) && ((rx_pass & rx_en) == rx_en);
    assign h_tx_mask   = pin3_source_group[0] ? tx1_map : tx0_map;
    assign h_tx_and    = (h_tx_mask != 4'h0) && ((rx_pass & h_tx_mask) == h_tx_mask);
    assign h_tx_fv     = tx_frame_valid[pin3_source_group[0]];
    assign h_tx_irq    = tx_irq[pin3_source_group[0]];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    property p_rx_lock;
        h_rx_src && pin3_signal_select == PSM_SEL_4 |=> pin_out_r == $past(h_rx_lock);
    endproperty
    a_rx_lock: assert property (p_rx_lock) else $error("pin does not follow port lock");

    property p_rx_pass;
        h_rx_src && pin3_signal_select == PSM_SEL_5 |=> pin_out_r == $past(h_rx_pass);
    endproperty
    a_rx_pass: assert property (p_rx_pass) else $error("pin does not follow port pass");

    property p_rx_remote;
        h_rx_src && !pin3_signal_select[2] |=> pin_out_r == $past(h_rx_remote);
    endproperty
    a_rx_remote: assert property (p_rx_remote) else $error("remote pin not forwarded");

    property p_rx_fv;
        h_rx_src && pin3_signal_select == PSM_SEL_6 |=> pin_out_r == $past(h_rx_fv);
    endproperty
    a_rx_fv: assert property (p_rx_fv) else $error("port frame valid not forwarded");

    property p_dev_level;
        pin3_source_group == PSM_SRC_DEV && pin3_signal_select == PSM_SEL_0
            |=> pin_out_r == $past(pin3_software_level);
    endproperty
    a_dev_level: assert property (p_dev_level) else $error("software level not driven");

    property p_dev_rsvd;
        (pin3_source_group == PSM_SRC_DEV && pin3_signal_select >= PSM_SEL_5) ||
        pin3_source_group == PSM_SRC_RSVD |=> !pin_out_r;
    endproperty
    a_dev_rsvd: assert property (p_dev_rsvd) else $error("reserved code drives high");

    property p_dev_or;
        pin3_source_group == PSM_SRC_DEV && pin3_signal_select == PSM_SEL_1
            |=> pin_out_r == $past(h_or_lock);
    endproperty
    a_dev_or: assert property (p_dev_or) else $error("lock or wrong");

    property p_dev_and_lock;
        pin3_source_group == PSM_SRC_DEV && pin3_signal_select == PSM_SEL_2
            |=> pin_out_r == $past(h_and_lock);
    endproperty
    a_dev_and_lock: assert property (p_dev_and_lock) else $error("lock and wrong");

    property p_dev_and_pass;
        pin3_source_group == PSM_SRC_DEV && pin3_signal_select == PSM_SEL_3
            |=> pin_out_r == $past(h_and_pass);
    endproperty
    a_dev_and_pass: assert property (p_dev_and_pass) else $error("pass and wrong");

    property p_dev_sync;
        pin3_source_group == PSM_SRC_DEV && pin3_signal_select == PSM_SEL_4
            |=> pin_out_r == $past(frame_sync_pulse);
    endproperty
    a_dev_sync: assert property (p_dev_sync) else $error("frame sync not forwarded");

    property p_tx_and;
        h_tx_src && pin3_signal_select == PSM_SEL_0 |=> pin_out_r == $past(h_tx_and);
    endproperty
    a_tx_and: assert property (p_tx_and) else $error("transmit pass and wrong");

    property p_tx_fv;
        h_tx_src && pin3_signal_select == PSM_SEL_2 |=> pin_out_r == $past(h_tx_fv);
    endproperty
    a_tx_fv: assert property (p_tx_fv) else $error("transmit frame valid wrong");

    property p_tx_irq;
        h_tx_src && pin3_signal_select == PSM_SEL_5 |=> pin_out_r == $past(h_tx_irq);
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("transmit interrupt wrong");

    property p_tx_rsvd;
        h_tx_src && pin3_signal_select >= PSM_SEL_6 |=> !pin_out_r;
    endproperty
    a_tx_rsvd: assert property (p_tx_rsvd) else $error("transmit reserved drives high");

    property p_level_write;
        wr_commit && wb_sel_i[0] && adr_hit(wb_adr_i, PSM_CTRL_ADR) |=>
            pin3_software_level == $past(wb_dat_i[PSM_VAL_BIT]) ##1 1'b1;
    endproperty
    a_level_write: assert property (p_level_write) else $error("level bit not stored");

    property p_enable;
        pin3_driver_enable != $past(pin3_driver_enable) |=> pin_oe_n_r == !$past(pin3_driver_enable);
    endproperty
    a_enable: assert property (p_enable) else $error("driver enable lags");

    property p_ack_pulse;
        req && !ack_r |=> ack_r ##1 !ack_r;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a single cycle");

    c_rx_lock: cover property (h_rx_src && pin3_signal_select == PSM_SEL_4 ##1 pin_out_r);
    c_dev_and: cover property (pin3_source_group == PSM_SRC_DEV && h_and_lock ##1 pin_out_r);
    c_tx_irq:  cover property (h_tx_src && pin3_signal_select == PSM_SEL_5 && h_tx_irq ##1 pin_out_r);
    c_drive:   cover property (pin_oe_n_r ##1 !pin_oe_n_r);

endmodule : psm_pin3_mux

// File: src/psm_pkg.sv
// Purpose: shared constants for the pin 3 output source multiplexer
// Assumes: classic Wishbone register access, 32-bit data, byte addresses
// Notes:   register indices are kept as printed; byte address is four times the index

// ============================================================
// package
// ============================================================
package psm_pkg;

    // ============================================================
    // bus and register map
    // ============================================================
    localparam int           PSM_ADR_W     = 8;
    localparam int           PSM_DAT_W     = 32;
    localparam logic [7:0]   PSM_CTRL_IDX  = 8'h13;              // pin3_output_control
    localparam logic [7:0]   PSM_CFG_IDX   = 8'h20;              // port enable and tx assignment
    localparam logic [7:0]   PSM_STAT_IDX  = 8'h21;              // live pin status
    localparam logic [7:0]   PSM_CTRL_ADR  = 8'(PSM_CTRL_IDX * 4);
    localparam logic [7:0]   PSM_CFG_ADR   = 8'(PSM_CFG_IDX * 4);
    localparam logic [7:0]   PSM_STAT_ADR  = 8'(PSM_STAT_IDX * 4);

    // ============================================================
    // field positions and reset values
    // ============================================================
    localparam int           PSM_SEL_MSB   = 7;
    localparam int           PSM_SEL_LSB   = 5;
    localparam int           PSM_SRC_MSB   = 4;
    localparam int           PSM_SRC_LSB   = 2;
    localparam int           PSM_VAL_BIT   = 1;
    localparam int           PSM_EN_BIT    = 0;
    localparam logic [7:0]   PSM_CTRL_RST  = 8'h00;
    localparam logic [11:0]  PSM_CFG_RST   = 12'h000;
    localparam int           PSM_RX_N      = 4;
    localparam int           PSM_TX_N      = 2;

    // ============================================================
    // source group codes
    // ============================================================
    localparam logic [2:0]   PSM_SRC_RX0   = 3'h0;
    localparam logic [2:0]   PSM_SRC_RX3   = 3'h3;
    localparam logic [2:0]   PSM_SRC_DEV   = 3'h4;
    localparam logic [2:0]   PSM_SRC_RSVD  = 3'h5;
    localparam logic [2:0]   PSM_SRC_TX0   = 3'h6;
    localparam logic [2:0]   PSM_SRC_TX1   = 3'h7;

    // ============================================================
    // signal select codes
    // ============================================================
    localparam logic [2:0]   PSM_SEL_0     = 3'h0;
    localparam logic [2:0]   PSM_SEL_1     = 3'h1;
    localparam logic [2:0]   PSM_SEL_2     = 3'h2;
    localparam logic [2:0]   PSM_SEL_3     = 3'h3;
    localparam logic [2:0]   PSM_SEL_4     = 3'h4;
    localparam logic [2:0]   PSM_SEL_5     = 3'h5;
    localparam logic [2:0]   PSM_SEL_6     = 3'h6;
    localparam logic [2:0]   PSM_SEL_7     = 3'h7;

endpackage : psm_pkg

// File: src/psm_source_select.sv
// Purpose: combinational pick of the pin 3 output level from source group and select
// Assumes: all status inputs synchronous to sys_clk
// Notes:   reserved codes drive a low level; empty port masks give a low result

`timescale 1ns/1ps

// ============================================================
// source selector
// ============================================================
module psm_source_select
    import psm_pkg::*;
(
    input  wire logic [2:0]  src,
    input  wire logic [2:0]  sel,
    input  wire logic        level,
    input  wire logic [3:0]  rx_en,
    input  wire logic [3:0]  tx0_map,
    input  wire logic [3:0]  tx1_map,
    input  wire logic [15:0] rx_remote_gpio,
    input  wire logic [3:0]  rx_lock,
    input  wire logic [3:0]  rx_pass,
    input  wire logic [3:0]  rx_frame_valid,
    input  wire logic [3:0]  rx_line_valid,
    input  wire logic        frame_sync_pulse,
    input  wire logic [1:0]  tx_frame_valid,
    input  wire logic [1:0]  tx_line_valid,
    input  wire logic [1:0]  tx_synced,
    input  wire logic [1:0]  tx_irq,
    output logic             sel_val
);

    // and over the masked ports, low when the mask is empty
    function automatic logic masked_and(input logic [3:0] v, input logic [3:0] m);
        return (|m) & (&(v | ~m));
    endfunction : masked_and

    // or over the masked ports
    function automatic logic masked_or(input logic [3:0] v, input logic [3:0] m);
        return |(v & m);
    endfunction : masked_or

    logic [1:0] rx_idx;
    logic       tx_idx;
    logic [3:0] tx_map;

    // port index and assignment mask taken from the source code
    assign rx_idx = src[1:0];
    assign tx_idx = src[0];
    assign tx_map = tx_idx ? tx1_map : tx0_map;

    // output level per group and select
    always_comb begin
        sel_val = 1'b0;
        if (!src[2]) begin
            unique case (sel)
                PSM_SEL_0, PSM_SEL_1, PSM_SEL_2, PSM_SEL_3: begin
                    sel_val = rx_remote_gpio[{rx_idx, sel[1:0]}];
                end
                PSM_SEL_4: sel_val = rx_lock[rx_idx];
                PSM_SEL_5: sel_val = rx_pass[rx_idx];
                PSM_SEL_6: sel_val = rx_frame_valid[rx_idx];
                PSM_SEL_7: sel_val = rx_line_valid[rx_idx];
            endcase
        end else if (src == PSM_SRC_DEV) begin
            unique case (sel)
                PSM_SEL_0: sel_val = level;
                PSM_SEL_1: sel_val = masked_or(rx_lock, rx_en);
                PSM_SEL_2: sel_val = masked_and(rx_lock, rx_en);
                PSM_SEL_3: sel_val = masked_and(rx_pass, rx_en);
                PSM_SEL_4: sel_val = frame_sync_pulse;
                PSM_SEL_5, PSM_SEL_6, PSM_SEL_7: sel_val = 1'b0;
            endcase
        end else if (src == PSM_SRC_TX0 || src == PSM_SRC_TX1) begin
            unique case (sel)
                PSM_SEL_0: sel_val = masked_and(rx_pass, tx_map);
                PSM_SEL_1: sel_val = masked_or(rx_pass, tx_map);
                PSM_SEL_2: sel_val = tx_frame_valid[tx_idx];
                PSM_SEL_3: sel_val = tx_line_valid[tx_idx];
                PSM_SEL_4: sel_val = tx_synced[tx_idx];
                PSM_SEL_5: sel_val = tx_irq[tx_idx];
                PSM_SEL_6, PSM_SEL_7: sel_val = 1'b0;
            endcase
        end else begin
            sel_val = 1'b0;
        end
    end

endmodule : psm_source_select

// File: tb/psm_pin_sampler.sv
// Purpose: model of the board logic that samples pin 3
// Assumes: pin has no pull resistor
// Notes:   an undriven pin shows the inverse of the last driven level
`timescale 1ns/1ps
module psm_pin_sampler (
    input  wire logic sys_clk,
    input  wire logic pin_out,
    input  wire logic pin_oe_n,
    output logic      pin_level
);
    logic             last_r;
    // remember the last driven level so a floating pin cannot look driven
    always_ff @(posedge sys_clk) begin
        if (!pin_oe_n) begin
            last_r <= pin_out;
        end
    end
    assign pin_level = pin_oe_n ? ~last_r : pin_out; // floating shows inverse
endmodule : psm_pin_sampler

// File: tb/tb_pin3_output_source_mux.sv
// Purpose: self-checking bench for the pin 3 output multiplexer
// Assumes: one idle cycle between bus requests
// Notes:   status inputs come from one packed stimulus word
`timescale 1ns/1ps
module tb_pin3_output_source_mux
    import psm_pkg::*;
;
    logic        sys_clk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, ack, p_out, p_oe_n, lvl;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wd = 32'h0, rd, q;
    logic [40:0] s = 41'h0;
    int          bad_count = 0, num_checks = 0, cyc_n = 0;
    // ============================================================
    // clock, timeout, instances
    // ============================================================
    initial forever #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    psm_pin3_mux uut (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
        .rx_remote_gpio(s[15:0]), .rx_lock(s[19:16]), .rx_pass(s[23:20]), .rx_frame_valid(s[27:24]),
        .rx_line_valid(s[31:28]), .frame_sync_pulse(s[32]), .tx_frame_valid(s[34:33]),
        .tx_line_valid(s[36:35]), .tx_synced(s[38:37]), .tx_irq(s[40:39]), .pin3_in(lvl),
        .pin3_out(p_out), .pin3_oe_n(p_oe_n));
    psm_pin_sampler sampler (.sys_clk(sys_clk), .pin_out(p_out), .pin_oe_n(p_oe_n), .pin_level(lvl));
    // ============================================================
    // helpers
    // ============================================================
    task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string msg);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk
    // one classic Wishbone cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wd <= d;
        do @(posedge sys_clk); while (ack !== 1'b1);
        q = rd;
        cyc <= 0;
        stb <= 0;
    endtask : wb
    // expected pin level worked out from the select table
    function automatic logic expv(input logic [2:0] sr, input logic [2:0] se, input logic [7:0] c,
                                  input logic [11:0] g);
        logic [3:0] m, e;
        m = sr[0] ? g[11:8] : g[7:4];
        e = g[3:0];
        if (sr < 3'h4) return se[2] ? s[16 + 4 * se[1:0] + sr[1:0]] : s[4 * sr[1:0] + se[1:0]];
        if (sr == 3'h5) return 1'b0;
        if (sr == 3'h4) begin
            case (se)
                3'h0: return c[1];
                3'h1: return |(s[19:16] & e);
                3'h2: return (e != 4'h0) & (&(s[19:16] | ~e));
                3'h3: return (e != 4'h0) & (&(s[23:20] | ~e));
                3'h4: return s[32];
                default: return 1'b0;
            endcase
        end
        case (se)
            3'h0: return (m != 4'h0) & (&(s[23:20] | ~m));
            3'h1: return |(s[23:20] & m);
            3'h2, 3'h3, 3'h4, 3'h5: return s[33 + 2 * (se - 3'h2) + sr[0]];
            default: return 1'b0;
        endcase
    endfunction : expv
    // ============================================================
    // scenarios
    // ============================================================
    task automatic t_regs();
        chk(32'h1, p_oe_n, "driver off after reset");
        wb(0, PSM_CTRL_ADR, 0);
        chk(32'h0, q, "control reset value");
        wb(1, PSM_CTRL_ADR, 32'hFFFF_FFB7);
        wb(0, PSM_CTRL_ADR, 0);
        chk(32'hB7, q, "control readback");
        wb(1, 8'h10, 32'hFF);
        wb(0, 8'h10, 0);
        chk(32'h0, q, "unmapped read");
        $display("test regs done");
    endtask : t_regs
    task automatic t_sweep(input logic [11:0] g);
        logic [7:0] c;
        wb(1, PSM_CFG_ADR, {20'h0, g});
        for (int k = 0; k < 64; k++) begin
            // level bit differs between the two sweeps for the software-level select
            c = {k[2:0], k[5:3], k[0] ^ k[3] ^ g[1], 1'b1};
            wb(1, PSM_CTRL_ADR, {24'h0, c});
            // third pattern leaves masks partly set, so masked and and or disagree
            for (int p = 0; p < 3; p++) begin
                s <= (p == 0) ? 41'h0A5_C396_F1E2 : (p == 1) ? 41'h15A_3C69_0E1D : 41'h0C3_3D52_4B96;
                repeat (2) @(posedge sys_clk);
                chk(expv(c[4:2], c[7:5], c, g), lvl, "pin level");
                chk(expv(c[4:2], c[7:5], c, g), p_out, "pin out");
                chk(32'h0, p_oe_n, "driver enabled");
            end
        end
        $display("test sweep done");
    endtask : t_sweep
    task automatic t_disable();
        wb(1, PSM_CTRL_ADR, 32'h12);
        repeat (2) @(posedge sys_clk);
        chk(32'h1, p_oe_n, "driver off");
        chk(32'h1, p_out, "pin level while undriven");
        wb(0, PSM_STAT_ADR, 0);
        chk(32'h0, q[2], "status enable bit");
        chk(32'h3, q[1:0], "status selected and pin level");
        chk(lvl, q[3], "status pin readback");
        chk(32'h0, q[31:4], "status upper bits");
        $display("test disable done");
    endtask : t_disable
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (2) @(posedge sys_clk);
        reset_n <= 1;
        @(posedge sys_clk);
        t_regs();
        t_sweep(12'hA56);
        t_sweep(12'h000);
        t_disable();
        tally_and_finish();
    end
endmodule : tb_pin3_output_source_mux
